// file: rtl/dma_mac_interrupt_status.sv
`timescale 1ns/1ps
module dma_mac_interrupt_status
   import dma_irq_pkg::*;
#(
   parameter int ADDR_COUNT = EXTRA_ADDR_COUNT
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire reg_req_t req,
   output logic [31:0] rdata,
   input wire dma_events_t ev,
   input wire logic [ADDR_COUNT-1:0] addr_high_enable,
   input wire logic [47:0] rx_dest_addr,
   input wire logic [15:0] addr_high_bytes [ADDR_COUNT],
   output logic addr_match,
   output logic tx_suspended,
   output logic rx_suspended,
   output logic irq
);
   // Word index is four bits wide, so more than sixteen filters cannot be decoded
   if (ADDR_COUNT < 1 || ADDR_COUNT > EXTRA_ADDR_COUNT) begin : g_bad_count
      $error("ADDR_COUNT out of range");
   end

   logic [6:0] flags_r;
   logic [6:0] flags_nxt;
   logic [6:0] enables_r;
   logic [31:0] addr_low_r [ADDR_COUNT];
   logic link_prev_r;
   logic tx_stop_prev_r;
   logic rx_stop_prev_r;
   logic rx_last_owned_r;
   logic [6:0] set_vec;
   logic [6:0] clr_vec;
   logic rx_unavail_evt;
   logic wr_flags;
   logic [3:0] addr_idx;
   logic addr_in_range;

   // ==========================================================
   // Address decode
   assign wr_flags = req.wr && req.addr == FLAGS_OFFSET;
   assign addr_in_range = req.addr >= EXTRA_ADDR_BASE && req.addr <= EXTRA_ADDR_LAST && req.addr[2] == 1'b0;
   assign addr_idx = req.addr[6:3];

   // ==========================================================
   // Event detection
   // Only the first host-owned fetch after a device-owned one counts
   assign rx_unavail_evt = ev.rx_desc_fetch && ev.rx_desc_host_owned && rx_last_owned_r;
   always_comb begin
      set_vec = '0;
      set_vec[LINK_CHANGE_BIT-FLAG_LSB] = ev.link_up != link_prev_r;
      set_vec[TX_DONE_BIT-FLAG_LSB] = ev.tx_frame_sent;
      set_vec[RX_DONE_BIT-FLAG_LSB] = ev.rx_frame_ready;
      set_vec[TX_UNAVAIL_BIT-FLAG_LSB] = ev.tx_desc_host_owned && !tx_suspended;
      set_vec[RX_UNAVAIL_BIT-FLAG_LSB] = rx_unavail_evt;
      set_vec[TX_STOPPED_BIT-FLAG_LSB] = ev.tx_stopped && !tx_stop_prev_r;
      set_vec[RX_STOPPED_BIT-FLAG_LSB] = ev.rx_stopped && !rx_stop_prev_r;
   end

   // Write-one clears; a set in the same cycle wins so no event is lost
   assign clr_vec = wr_flags ? req.wdata[31:FLAG_LSB] : 7'h00;
   assign flags_nxt = (flags_r & ~clr_vec) | set_vec;

   // Edge history; link level is taken as down at reset
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         link_prev_r <= 1'b0;
         tx_stop_prev_r <= 1'b0;
         rx_stop_prev_r <= 1'b0;
         rx_last_owned_r <= 1'b1;
      end else begin
         link_prev_r <= ev.link_up;
         tx_stop_prev_r <= ev.tx_stopped;
         rx_stop_prev_r <= ev.rx_stopped;
         if (ev.rx_desc_fetch) begin
            rx_last_owned_r <= !ev.rx_desc_host_owned;
         end
      end
   end

   // Status flags; reads have no side effect on them
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         flags_r <= FLAGS_RESET;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   // Enable register
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         enables_r <= ENABLES_RESET;
      end else if (req.wr && req.addr == ENABLES_OFFSET) begin
         enables_r <= req.wdata[31:FLAG_LSB];
      end
   end

   // Extra station address low words
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < ADDR_COUNT; i++) begin
            addr_low_r[i] <= ADDR_LOW_RESET;
         end
      end else if (req.wr && addr_in_range && int'(addr_idx) < ADDR_COUNT) begin
         addr_low_r[addr_idx] <= req.wdata;
      end
   end

   // ==========================================================
   // Suspend state of the descriptor engines
   // Transmit waits for the host's start command after returning ownership
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         tx_suspended <= 1'b0;
      end else if (ev.tx_start_cmd) begin
         tx_suspended <= 1'b0;
      end else if (ev.tx_desc_host_owned) begin
         tx_suspended <= 1'b1;
      end
   end

   // Receive resumes on its own; a recognized frame outranks a host-owned fetch
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rx_suspended <= 1'b0;
      end else if (ev.rx_start_cmd || ev.rx_frame_recognized) begin
         rx_suspended <= 1'b0;
      end else if (ev.rx_desc_fetch && ev.rx_desc_host_owned) begin
         rx_suspended <= 1'b1;
      end
   end

   // ==========================================================
   // Read data, interrupt and address match, all registered
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rdata <= 32'h0000_0000;
      end else if (req.rd) begin
         if (req.addr == FLAGS_OFFSET) begin
            rdata <= {flags_r, 25'h0000000};
         end else if (req.addr == ENABLES_OFFSET) begin
            rdata <= {enables_r, 25'h0000000};
         end else if (addr_in_range && int'(addr_idx) < ADDR_COUNT) begin
            rdata <= addr_low_r[addr_idx];
         end else begin
            rdata <= 32'h0000_0000;
         end
      end
   end

   // Uses next flag value so irq tracks flags without an extra cycle
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(flags_nxt & enables_r);
      end
   end

   // Any enabled filter that equals the destination gives a match
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         addr_match <= 1'b0;
      end else begin
         addr_match <= 1'b0;
         for (int i = 0; i < ADDR_COUNT; i++) begin
            if (addr_high_enable[i] && rx_dest_addr == {addr_high_bytes[i], addr_low_r[i]}) begin
               addr_match <= 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // Checks
   // These watch flops, decoded events, raw event inputs and write data; bus legality is left to the bench
   a_flag_hold: assert property (@(posedge core_clk) disable iff (!resetn)
      (flags_r & ~$past(flags_r) & ~$past(set_vec)) == 7'h00) else $error("flag rose without event");
   a_flag_sticky: assert property (@(posedge core_clk) disable iff (!resetn)
      !wr_flags |=> (flags_r & $past(flags_r)) == $past(flags_r)) else $error("flag cleared without write");
   a_w1c_clear: assert property (@(posedge core_clk) disable iff (!resetn)
      (wr_flags && req.wdata[31] && ev.link_up == link_prev_r) |=> !flags_r[6]) else $error("w1c failed");
   a_irq_mask: assert property (@(posedge core_clk) disable iff (!resetn)
      irq |-> (flags_r & $past(enables_r)) != 7'h00) else $error("irq without enabled flag");
   a_irq_raise: assert property (@(posedge core_clk) disable iff (!resetn)
      (|(flags_r & enables_r) && !wr_flags) |=> irq) else $error("irq missing");
   a_link_edge: assert property (@(posedge core_clk) disable iff (!resetn)
      (ev.link_up != link_prev_r) |=> flags_r[6]) else $error("link change lost");
   a_rx_once: assert property (@(posedge core_clk) disable iff (!resetn)
      (ev.rx_desc_fetch && ev.rx_desc_host_owned ##1 ev.rx_desc_fetch && ev.rx_desc_host_owned)
      |-> !rx_unavail_evt) else $error("repeat rx unavailable");
   a_tx_stop_set: assert property (@(posedge core_clk) disable iff (!resetn)
      $rose(ev.tx_stopped) |=> flags_r[1]) else $error("tx stop lost");
   a_rx_stop_set: assert property (@(posedge core_clk) disable iff (!resetn)
      $rose(ev.rx_stopped) |=> flags_r[0]) else $error("rx stop lost");
   a_rx_resume: assert property (@(posedge core_clk) disable iff (!resetn)
      ev.rx_frame_recognized |=> !rx_suspended) else $error("rx not resumed");
   a_tx_suspend: assert property (@(posedge core_clk) disable iff (!resetn)
      (ev.tx_desc_host_owned && !ev.tx_start_cmd) |=> tx_suspended) else $error("tx not suspended");
   a_rx_suspend: assert property (@(posedge core_clk) disable iff (!resetn)
      (ev.rx_desc_fetch && ev.rx_desc_host_owned && !ev.rx_start_cmd && !ev.rx_frame_recognized)
      |=> rx_suspended) else $error("rx not suspended");
endmodule

// file: shared/dma_irq_pkg.sv
package dma_irq_pkg;
   // ==========================================================
   // Register map
   localparam logic [7:0] ENABLES_OFFSET = 8'h28;
   localparam logic [7:0] FLAGS_OFFSET = 8'h2C;
   localparam logic [7:0] EXTRA_ADDR_BASE = 8'h80;
   localparam logic [7:0] EXTRA_ADDR_LAST = 8'hFC;
   localparam int EXTRA_ADDR_COUNT = 16;
   // ==========================================================
   // Field positions
   localparam int LINK_CHANGE_BIT = 31;
   localparam int TX_DONE_BIT = 30;
   localparam int RX_DONE_BIT = 29;
   localparam int TX_UNAVAIL_BIT = 28;
   localparam int RX_UNAVAIL_BIT = 27;
   localparam int TX_STOPPED_BIT = 26;
   localparam int RX_STOPPED_BIT = 25;
   localparam int FLAG_LSB = 25;
   localparam int FLAG_COUNT = 7;
   localparam int ADDR_ENABLE_BIT = 31;
   // ==========================================================
   // Reset values
   localparam logic [6:0] FLAGS_RESET = 7'h00;
   localparam logic [6:0] ENABLES_RESET = 7'h00;
   localparam logic [31:0] ADDR_LOW_RESET = 32'h0000_0000;

   // Register access from the processor side
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [31:0] wdata;
   } reg_req_t;

   // Event strobes and levels from the MAC and descriptor engines
   typedef struct packed {
      logic link_up;
      logic tx_frame_sent;
      logic rx_frame_ready;
      logic tx_desc_host_owned;
      logic rx_desc_fetch;
      logic rx_desc_host_owned;
      logic rx_frame_recognized;
      logic tx_start_cmd;
      logic rx_start_cmd;
      logic tx_stopped;
      logic rx_stopped;
   } dma_events_t;
endpackage

// file: test/host_cpu_model.sv
`timescale 1ns/1ps
// ==========================================================
// Host processor side: one register access per call
module host_cpu_model
   import dma_irq_pkg::*;
(
   input wire logic core_clk,
   input wire logic [31:0] rdata,
   output reg_req_t req
);
   initial req = '0;
   // Strobe rises after a falling edge and spans exactly one rising edge
   task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(negedge core_clk);
      req = '{rd: !w, wr: w, addr: a, wdata: d};
      @(negedge core_clk);
      req = '0;
      q = rdata; // Registered read data has landed by now
   endtask
endmodule

// file: test/dma_mac_interrupt_status_bench.sv
`timescale 1ns/1ps
module dma_mac_interrupt_status_bench
   import dma_irq_pkg::*;
;
   logic core_clk, resetn, addr_match, tx_suspended, rx_suspended, irq;
   reg_req_t req;
   dma_events_t ev;
   logic [31:0] rdata, q, fl, en, m;
   logic [31:0] lw [16];
   logic [15:0] addr_high_enable;
   logic [47:0] rx_dest_addr;
   logic [15:0] addr_high_bytes [16];
   int n_mismatch = 0;
   int n_checks = 0;
   // Event per flag, bit 31 down to 25
   logic [10:0] tab [7] = '{11'h400, 11'h200, 11'h100, 11'h080, 11'h060, 11'h002, 11'h001};
   dma_mac_interrupt_status u_dma_mac_interrupt_status (.core_clk(core_clk), .resetn(resetn), .req(req),
      .rdata(rdata), .ev(ev), .addr_high_enable(addr_high_enable), .rx_dest_addr(rx_dest_addr),
      .addr_high_bytes(addr_high_bytes), .addr_match(addr_match), .tx_suspended(tx_suspended),
      .rx_suspended(rx_suspended), .irq(irq));
   host_cpu_model u_host_cpu_model (.core_clk(core_clk), .rdata(rdata), .req(req));
   // ==========================================================
   // Helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      u_host_cpu_model.access(1'b1, a, d, x);
   endtask
   task automatic rd(input logic [7:0] a);
      u_host_cpu_model.access(1'b0, a, 32'h0, q);
   endtask
   // Toggle events over one rising edge; levels go back so a later entry is a fresh edge
   task automatic pulse(input logic [10:0] p);
      @(negedge core_clk);
      ev = ev ^ p;
      @(negedge core_clk);
      ev = ev ^ p;
   endtask
   function automatic logic exp_irq(input logic [31:0] f, input logic [31:0] e);
      return |(f & e & 32'hFE00_0000);
   endfunction
   // ==========================================================
   // Clock and watchdog; the run needs well under a thousand cycles
   initial begin
      core_clk = 0;
      forever #4 core_clk = ~core_clk;
   end
   initial begin
      #40000;
      n_mismatch++;
      give_verdict();
   end
   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(68931));
      resetn = 0;
      ev = '0;
      rx_dest_addr = 48'h0;
      addr_high_enable = 16'h0;
      foreach (addr_high_bytes[i]) addr_high_bytes[i] = 16'h0;
      repeat (2) @(negedge core_clk);
      resetn = 1;
      rd(FLAGS_OFFSET); check(q, 32'h0);
      rd(ENABLES_OFFSET); check(q, 32'h0);
      // One event at a time raises only its own flag
      for (int i = 0; i < 7; i++) begin
         wr(FLAGS_OFFSET, 32'hFE00_0000);
         pulse(tab[i]);
         rd(FLAGS_OFFSET); check(q, 32'h8000_0000 >> i);
      end
      check({tx_suspended, rx_suspended}, 2'b11);
      // Repeated host-owned fetch stays quiet until a device-owned one intervenes
      wr(FLAGS_OFFSET, 32'hFE00_0000);
      pulse(11'h060);
      rd(FLAGS_OFFSET); check(q, 32'h0);
      pulse(11'h040);
      // Two host-owned fetches on adjacent edges; only the first may flag
      @(negedge core_clk);
      ev = ev ^ 11'h060;
      repeat (2) @(negedge core_clk);
      ev = ev ^ 11'h060;
      rd(FLAGS_OFFSET); check(q, 32'h0800_0000);
      wr(FLAGS_OFFSET, 32'hFE00_0000);
      pulse(11'h060);
      rd(FLAGS_OFFSET); check(q, 32'h0);
      pulse(11'h010);
      check(rx_suspended, 1'b0);
      pulse(11'h008); // Transmit start command after the earlier host-owned descriptor
      check(tx_suspended, 1'b0);
      pulse(11'h040);
      pulse(11'h7E3);
      check({tx_suspended, rx_suspended}, 2'b11);
      pulse(11'h004); // Receive start command instead of a recognized frame
      check(rx_suspended, 1'b0);
      fl = 32'hFE00_0000;
      // Random masks and partial clears; zeros written must leave flags alone
      for (int k = 0; k < 20; k++) begin
         pulse(11'h400);
         fl[31] = 1'b1;
         en = $urandom;
         wr(ENABLES_OFFSET, en);
         repeat (2) @(negedge core_clk);
         check(irq, exp_irq(fl, en));
         rd(ENABLES_OFFSET); check(q, en & 32'hFE00_0000);
         m = (k == 0) ? 32'h0 : $urandom;
         wr(FLAGS_OFFSET, m);
         fl = fl & ~m;
         rd(FLAGS_OFFSET); check(q, fl);
         rd(FLAGS_OFFSET); check(q, fl);
      end
      // Address low words, with refused offsets in between
      foreach (lw[i]) begin
         lw[i] = $urandom;
         wr(EXTRA_ADDR_BASE + 8'(8 * i), lw[i]);
      end
      foreach (lw[i]) begin
         rd(EXTRA_ADDR_BASE + 8'(8 * i)); check(q, lw[i]);
      end
      rd(8'h84); check(q, 32'h0);
      addr_high_bytes[3] = 16'($urandom);
      rx_dest_addr = {addr_high_bytes[3], lw[3]};
      addr_high_enable = 16'h0008;
      repeat (2) @(negedge core_clk);
      check(addr_match, 1'b1);
      addr_high_enable = 16'h0;
      repeat (2) @(negedge core_clk);
      check(addr_match, 1'b0);
      give_verdict();
   end
endmodule
